// >>> twu_flag_handshake.sv
// Operation-complete flag handshake and byte engine of the two-wire unit.
// Assumes software drives the control and data write strobes on clk; bus pins are open drain and asynchronous.
`timescale 1ns/1ns
`default_nettype none
module twu_flag_handshake #(
  parameter int unsigned QTR_CYC = twu_pkg::TWU_QTR_CYC
) (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  // Control register write
  input  wire logic                              ctrl_wr,
  input  wire logic [twu_pkg::TWU_CTL_W-1:0]     ctrl_wdata,
  // Data register write and read
  input  wire logic                              data_wr,
  input  wire logic [twu_pkg::TWU_DATA_W-1:0]    data_wdata,
  output var  logic [twu_pkg::TWU_DATA_W-1:0]    data_rd,
  // Status
  output var  logic                              op_done_flag,
  output var  logic                              ack_seen,
  output var  logic                              busy,
  // Clock pin
  input  wire logic                              scl_i,
  output var  logic                              scl_o,
  output var  logic                              scl_oe,
  // Data pin
  input  wire logic                              sda_i,
  output var  logic                              sda_o,
  output var  logic                              sda_oe
);
  import twu_pkg::*;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic       scl_m_r;
  logic       scl_s_r;
  logic       sda_m_r;
  logic       sda_s_r;

  // Two flops per pin before any logic reads it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
    end
  end

  // ****************************************************
  // Quarter-bit enable
  // ****************************************************
  logic tick;

  twu_tick #(
    .DIV (QTR_CYC),
    .W   (TWU_DIV_W)
  ) u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (tick)
  );

  // ****************************************************
  // Engine state
  // ****************************************************
  twu_state_e              state_r;
  twu_state_e              state_nxt;
  logic [1:0]              ph_r;
  logic [1:0]              ph_nxt;
  logic [3:0]              bit_r;
  logic [3:0]              bit_nxt;
  logic                    flag_r;
  logic                    flag_nxt;
  logic [TWU_DATA_W-1:0]   data_r;
  logic [TWU_DATA_W-1:0]   data_nxt;
  logic                    ack_r;
  logic                    ack_nxt;
  logic                    recv_r;
  logic                    recv_nxt;
  logic                    acken_r;
  logic                    acken_nxt;
  logic                    scl_oe_r;
  logic                    scl_oe_nxt;
  logic                    sda_oe_r;
  logic                    sda_oe_nxt;
  logic                    pin_lvl_r;
  logic                    busy_r;
  logic                    busy_nxt;
  logic                    clr_wr;
  logic                    need_high;
  logic                    adv;

  // Phase advance; sampling phases wait for the clock line to be seen high
  always_comb begin
    clr_wr    = ctrl_wr && ctrl_wdata[TWU_F_FLAG];
    need_high = (state_r != TWU_IDLE) && (ph_r == TWU_PH2);
    adv       = tick && (!need_high || scl_s_r);
  end

  // Next-state logic of flag, data and pins
  always_comb begin
    state_nxt  = state_r;
    ph_nxt     = ph_r;
    bit_nxt    = bit_r;
    flag_nxt   = flag_r;
    data_nxt   = data_r;
    ack_nxt    = ack_r;
    recv_nxt   = recv_r;
    acken_nxt  = acken_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    // Data register is writable only while no byte is shifting
    if (data_wr && (state_r == TWU_IDLE)) begin
      data_nxt = data_wdata;
    end
    if (clr_wr) begin
      flag_nxt = 1'b0;
    end
    case (state_r)
      TWU_IDLE: begin
        // Only a clearing write launches an operation
        if (clr_wr && ctrl_wdata[TWU_F_EN]) begin
          ph_nxt = TWU_PH0;
          if (ctrl_wdata[TWU_F_START]) begin
            state_nxt = TWU_START;
          end else if (ctrl_wdata[TWU_F_STOP]) begin
            state_nxt = TWU_STOP;
          end else begin
            state_nxt = TWU_BIT;
            bit_nxt   = TWU_BIT_ZERO;
            recv_nxt  = ctrl_wdata[TWU_F_RECV];
            acken_nxt = ctrl_wdata[TWU_F_ACK];
          end
        end
      end
      TWU_START: begin
        if (adv) begin
          ph_nxt = ph_r + TWU_PH1;
          case (ph_r)
            TWU_PH0: sda_oe_nxt = 1'b0;
            TWU_PH1: scl_oe_nxt = 1'b0;
            TWU_PH2: sda_oe_nxt = 1'b1;
            default: begin
              scl_oe_nxt = 1'b1;
              flag_nxt   = 1'b1;
              state_nxt  = TWU_IDLE;
            end
          endcase
        end
      end
      TWU_BIT: begin
        if (adv) begin
          ph_nxt = ph_r + TWU_PH1;
          case (ph_r)
            TWU_PH0: begin
              scl_oe_nxt = 1'b1;
              if (bit_r == TWU_ACK_SLOT) begin
                sda_oe_nxt = recv_r && acken_r;
              end else begin
                sda_oe_nxt = !recv_r && !data_r[TWU_DATA_W-1];
              end
            end
            TWU_PH1: scl_oe_nxt = 1'b0;
            TWU_PH2: begin
              // Data register shifts in each data bit seen on the bus; the ack slot updates ack only
              if (bit_r == TWU_ACK_SLOT) begin
                ack_nxt = !sda_s_r;
              end else begin
                data_nxt = {data_r[TWU_DATA_W-2:0], sda_s_r};
              end
            end
            default: begin
              scl_oe_nxt = 1'b1;
              if (bit_r == TWU_ACK_SLOT) begin
                sda_oe_nxt = 1'b0;
                flag_nxt   = 1'b1;
                state_nxt  = TWU_IDLE;
              end else begin
                bit_nxt = bit_r + TWU_BIT_ONE;
              end
            end
          endcase
        end
      end
      TWU_STOP: begin
        if (adv) begin
          ph_nxt = ph_r + TWU_PH1;
          case (ph_r)
            TWU_PH0: begin
              scl_oe_nxt = 1'b1;
              sda_oe_nxt = 1'b1;
            end
            TWU_PH1: scl_oe_nxt = 1'b0;
            default: begin
              sda_oe_nxt = 1'b0;
              state_nxt  = TWU_IDLE;
            end
          endcase
        end
      end
      default: state_nxt = TWU_IDLE;
    endcase
    // Stretch the bus clock while the flag waits for software
    scl_oe_nxt = scl_oe_nxt || flag_nxt;
    busy_nxt   = (state_nxt != TWU_IDLE);
  end

  // Register engine state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= TWU_IDLE;
      ph_r      <= TWU_PH0;
      bit_r     <= TWU_BIT_ZERO;
      flag_r    <= 1'b0;
      data_r    <= TWU_DATA_RST;
      ack_r     <= 1'b0;
      recv_r    <= 1'b0;
      acken_r   <= 1'b0;
      scl_oe_r  <= 1'b0;
      sda_oe_r  <= 1'b0;
      pin_lvl_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      ph_r      <= ph_nxt;
      bit_r     <= bit_nxt;
      flag_r    <= flag_nxt;
      data_r    <= data_nxt;
      ack_r     <= ack_nxt;
      recv_r    <= recv_nxt;
      acken_r   <= acken_nxt;
      scl_oe_r  <= scl_oe_nxt;
      sda_oe_r  <= sda_oe_nxt;
      pin_lvl_r <= 1'b0;
      busy_r    <= busy_nxt;
    end
  end

  // Outputs straight from flops
  assign data_rd      = data_r;
  assign op_done_flag = flag_r;
  assign ack_seen     = ack_r;
  assign busy         = busy_r;
  assign scl_o        = pin_lvl_r;
  assign sda_o        = pin_lvl_r;
  assign scl_oe       = scl_oe_r;
  assign sda_oe       = sda_oe_r;

  // ****************************************************
  // Assertions
  // ****************************************************
  sequence s_byte_end;
    state_r == TWU_BIT && bit_r == TWU_ACK_SLOT && ph_r == TWU_PH3 && tick;
  endsequence

  sequence s_start_end;
    state_r == TWU_START && ph_r == TWU_PH3 && tick;
  endsequence

  a_byte_sets_flag: assert property (@(posedge clk) disable iff (!arst_n)
    s_byte_end |=> flag_r && state_r == TWU_IDLE) else $error("flag not set after byte");
  a_start_sets_flag: assert property (@(posedge clk) disable iff (!arst_n)
    s_start_end |=> flag_r && scl_oe_r) else $error("flag not set after start");
  a_flag_holds_scl: assert property (@(posedge clk) disable iff (!arst_n)
    flag_r |-> scl_oe_r && !busy) else $error("clock not held under flag");
  a_one_clears_flag: assert property (@(posedge clk) disable iff (!arst_n)
    flag_r && clr_wr |=> !flag_r) else $error("flag not cleared");
  a_zero_keeps_flag: assert property (@(posedge clk) disable iff (!arst_n)
    flag_r && !clr_wr |=> flag_r) else $error("flag lost");
  a_write_starts_op: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == TWU_IDLE && clr_wr && ctrl_wdata[TWU_F_EN] |=> busy && ph_r == TWU_PH0)
    else $error("operation did not start");
  a_start_chosen: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == TWU_IDLE && clr_wr && ctrl_wdata[TWU_F_EN] && ctrl_wdata[TWU_F_START] |=> state_r == TWU_START)
    else $error("wrong operation");
  a_no_op_flag: assert property (@(posedge clk) disable iff (!arst_n)
    flag_r && !clr_wr |=> !busy && flag_r) else $error("operation under flag");
  a_stop_no_flag: assert property (@(posedge clk) disable iff (!arst_n)
    state_r == TWU_STOP && ph_r == TWU_PH2 && adv |=> !flag_r && !busy && !sda_oe_r) else $error("flag after stop");

endmodule // twu_flag_handshake
`default_nettype wire

// >>> twu_pkg.sv
// Constants, control word layout and engine states for the two-wire unit flag handshake.
// Assumes a single clk domain at 20 MHz. The package holds no logic.
package twu_pkg;

  // ****************************************************
  // Control word layout
  // ****************************************************
  localparam int unsigned TWU_CTL_W     = 8;
  localparam int unsigned TWU_F_FLAG    = 7;  // Write 1 clears the operation-complete flag
  localparam int unsigned TWU_F_ACK     = 6;  // Acknowledge a received byte
  localparam int unsigned TWU_F_START   = 5;  // Send a start condition
  localparam int unsigned TWU_F_STOP    = 4;  // Send a stop condition
  localparam int unsigned TWU_F_EN      = 2;  // Unit enable
  localparam int unsigned TWU_F_RECV    = 1;  // Next byte is received, not sent

  // ****************************************************
  // Data and bit counting
  // ****************************************************
  localparam int unsigned TWU_DATA_W    = 8;
  localparam logic [7:0]  TWU_DATA_RST  = 8'hFF;
  localparam logic [3:0]  TWU_ACK_SLOT  = 4'h8;
  localparam logic [3:0]  TWU_BIT_ONE   = 4'h1;
  localparam logic [3:0]  TWU_BIT_ZERO  = 4'h0;

  // ****************************************************
  // Timing: one quarter of a bit period
  // ****************************************************
  localparam int unsigned TWU_CLK_NS    = 50;
  localparam int unsigned TWU_QTR_NS    = 2500;
  localparam int unsigned TWU_QTR_CYC   = (TWU_QTR_NS + TWU_CLK_NS - 1) / TWU_CLK_NS;
  localparam int unsigned TWU_DIV_W     = 8;

  // ****************************************************
  // Phases and states
  // ****************************************************
  localparam logic [1:0]  TWU_PH0       = 2'h0;
  localparam logic [1:0]  TWU_PH1       = 2'h1;
  localparam logic [1:0]  TWU_PH2       = 2'h2;
  localparam logic [1:0]  TWU_PH3       = 2'h3;

  typedef enum logic [1:0] {
    TWU_IDLE  = 2'b00,
    TWU_START = 2'b01,
    TWU_BIT   = 2'b10,
    TWU_STOP  = 2'b11
  } twu_state_e;

endpackage

// >>> twu_tick.sv
// Quarter-bit enable divider for the two-wire unit.
// Assumes one free-running clk; emits a one-cycle pulse every DIV cycles.
`timescale 1ns/1ns
`default_nettype none
module twu_tick #(
  parameter int unsigned DIV = twu_pkg::TWU_QTR_CYC,
  parameter int unsigned W   = twu_pkg::TWU_DIV_W
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Enable pulse
  output var  logic tick
);
  import twu_pkg::*;

  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] ZERO = '0;
  localparam logic [W-1:0] ONE  = W'(1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_r;
  logic         tick_nxt;

  // Next count and pulse
  always_comb begin
    tick_nxt = (cnt_r == LAST);
    cnt_nxt  = tick_nxt ? ZERO : cnt_r + ONE;
  end

  // Register the divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= ZERO;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule // twu_tick
`default_nettype wire

// >>> twu_bus_model.sv
// Behavioural target device on the two-wire bus, used by the flag handshake bench.
// Assumes the bench resolves both open-drain lines with pull-ups; clk only times clock stretching.
`timescale 1ns/1ns
`default_nettype none
module twu_bus_model (
  // Clock and bus lines
  input  wire logic       clk,
  input  wire logic       scl,
  input  wire logic       sda,
  // Set-up from the bench
  input  wire logic [7:0] tx_byte,
  input  wire logic [3:0] stretch,
  // Line pulls and observations
  output var  logic       scl_pull,
  output var  logic       sda_pull,
  output var  logic [7:0] rx_byte,
  output var  logic       got_stop
);
  int   bitn;
  logic first;
  logic reading;

  // Everything released until the first start
  initial begin
    bitn = 0;
    first = 1'b0;
    reading = 1'b0;
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    rx_byte = 8'h00;
    got_stop = 1'b0;
  end

  // Start and stop conditions
  always @(negedge sda) if (scl === 1'b1) begin
    bitn = 0;
    first = 1'b1;
    reading = 1'b0;
    got_stop = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) got_stop = 1'b1;

  // Sample data and acknowledge slots; address bit 0 picks the direction, a NACK ends reading
  always @(posedge scl) begin
    if (bitn < 8) rx_byte = {rx_byte[6:0], sda};
    else if (first) begin
      reading = rx_byte[0];
      first = 1'b0;
    end
    else if (reading && sda) reading = 1'b0;
    bitn = (bitn == 8) ? 0 : bitn + 1;
  end

  // Drive on the falling clock edge, then stretch the low phase
  always @(negedge scl) begin
    if (bitn == 8) sda_pull = !reading;
    else sda_pull = reading && !tx_byte[7-bitn];
    if (stretch != 4'h0) begin
      scl_pull = 1'b1;
      repeat (stretch) @(posedge clk);
      scl_pull = 1'b0;
    end
  end
endmodule // twu_bus_model
`default_nettype wire

// >>> twu_flag_handshake_bench.sv
// Self-checking bench for the two-wire unit flag handshake.
// Assumes the design and its package are compiled first; the bus model stands on the far side.
`timescale 1ns/1ns
`default_nettype none
module twu_flag_handshake_bench;
  import twu_pkg::*;
  localparam int unsigned QC = 4;

  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  ctrl_wr = 1'b0;
  logic [TWU_CTL_W-1:0]  ctrl_wdata = 8'h00;
  logic                  data_wr = 1'b0;
  logic [TWU_DATA_W-1:0] data_wdata = 8'h00;
  logic [TWU_DATA_W-1:0] data_rd;
  logic                  op_done_flag, ack_seen, busy;
  logic                  scl_o, scl_oe, sda_o, sda_oe;
  logic                  m_scl, m_sda, got_stop;
  logic [7:0]            rx_byte;
  logic [7:0]            tx_byte = 8'h3C;
  logic [3:0]            stretch = 4'h2;
  wire logic             scl, sda;
  int                    bad_count = 0;
  int                    compares = 0;

  // Clock and wired-and bus lines with pull-ups
  always #25 clk = ~clk;
  assign scl = ((scl_oe && !scl_o) || m_scl) ? 1'b0 : 1'b1;
  assign sda = ((sda_oe && !sda_o) || m_sda) ? 1'b0 : 1'b1;

  twu_flag_handshake #(.QTR_CYC(QC)) dut_u (.clk(clk), .arst_n(arst_n), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd),
    .op_done_flag(op_done_flag), .ack_seen(ack_seen), .busy(busy), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  twu_bus_model bus_u (.clk(clk), .scl(scl), .sda(sda), .tx_byte(tx_byte), .stretch(stretch),
    .scl_pull(m_scl), .sda_pull(m_sda), .rx_byte(rx_byte), .got_stop(got_stop));

  // ****************************************************
  // Shared tasks
  // ****************************************************
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Move to just after a later rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic ctl_write(input logic [7:0] w);
    ctrl_wdata = w;
    ctrl_wr = 1'b1;
    step(1);
    ctrl_wr = 1'b0;
  endtask

  task automatic wait_on(input bit on_busy, input logic want);
    int n = 0;
    while (((on_busy ? busy : op_done_flag) !== want) && n < 3000) begin
      step(1);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      $display("Error wait_on expected %b seen timeout", want);
      final_report();
    end
  endtask

  // Counts cycles in which the flag keeps its level, the engine stays idle and scl is the inverse of the flag
  task automatic hold_count(input logic flag, input string name);
    int held = 0;
    repeat (40) begin
      step(1);
      if (op_done_flag === flag && busy === 1'b0 && scl === !flag) held++;
    end
    check(name, 8'(held), 8'h28);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_reset();
    check("flag_rst", {7'h00, op_done_flag}, 8'h00);
    check("busy_rst", {7'h00, busy}, 8'h00);
    check("data_rst", data_rd, TWU_DATA_RST);
    check("oe_rst", {6'h00, scl_oe, sda_oe}, 8'h00);
    check("pin_lvl", {6'h00, scl_o, sda_o}, 8'h00);
  endtask

  task automatic t_start();
    ctl_write(8'hA4);
    check("start_busy", {6'h00, busy, op_done_flag}, 8'h02);
    wait_on(1'b0, 1'b1);
    check("start_done", {6'h00, busy, scl_oe}, 8'h01);
  endtask

  task automatic t_hold();
    ctl_write(8'h24);
    hold_count(1'b1, "flag_kept");
  endtask

  task automatic t_send();
    data_wdata = 8'hA5;
    data_wr = 1'b1;
    step(1);
    data_wr = 1'b0;
    check("data_load", data_rd, 8'hA5);
    ctl_write(8'h84);
    check("send_busy", {6'h00, busy, op_done_flag}, 8'h02);
    wait_on(1'b0, 1'b1);
    check("send_byte", rx_byte, 8'hA5);
    check("send_ack", {6'h00, ack_seen, scl_oe}, 8'h03);
    check("send_data", data_rd, 8'hA5);
  endtask

  task automatic t_recv();
    stretch = 4'h3;
    // Received byte acknowledged by the unit, so the target keeps sending
    ctl_write(8'hC6);
    wait_on(1'b0, 1'b1);
    check("recv_ack_data", data_rd, 8'h3C);
    check("recv_ack", {6'h00, ack_seen, scl_oe}, 8'h03);
    ctl_write(8'h86);
    step(2);
    data_wdata = 8'h00;
    data_wr = 1'b1;
    step(1);
    data_wr = 1'b0;
    wait_on(1'b0, 1'b1);
    check("recv_data", data_rd, 8'h3C);
    check("recv_nack", {6'h00, ack_seen, scl_oe}, 8'h01);
  endtask

  task automatic t_stop();
    ctl_write(8'h94);
    check("stop_busy", {6'h00, busy, op_done_flag}, 8'h02);
    wait_on(1'b1, 1'b0);
    hold_count(1'b0, "stop_idle");
    check("stop_seen", {7'h00, got_stop}, 8'h01);
    check("stop_lines", {6'h00, scl_oe, sda_oe}, 8'h00);
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    step(6);
    arst_n = 1'b1;
    t_reset();
    t_start();
    t_hold();
    t_send();
    t_recv();
    t_stop();
    final_report();
  end
endmodule // twu_flag_handshake_bench
`default_nettype wire
